// ### console_access_pkg.sv
/*
  Shared constants for the operator console storage access block.
  Assumes a 16-bit processor data path with bit 0 as the most significant bit.
*/
package console_access_pkg;

  localparam int unsigned WORD_W       = 16;
  localparam int unsigned STACK_W      = 3;
  localparam int unsigned ENTRY_W      = 5;
  localparam int unsigned SEG_W        = 11;
  localparam int unsigned LEVEL_W      = 2;
  localparam int unsigned PHYS_W       = 20;

  // Stack key and entry number locations
  localparam int unsigned ENTRY_LSB    = 11;
  localparam int unsigned KEY_LSB      = 0;

  // Segmentation entry: block bits 15:7, valid bit 6, read-only bit 5
  localparam int unsigned SEG_BLK_LSB  = 7;
  localparam int unsigned SEG_VALID    = 6;
  localparam int unsigned SEG_RO       = 5;
  localparam int unsigned BLK_W        = 9;

  // Status word bits, numbered from the least significant end
  localparam int unsigned PSW_INV_ADDR = 14;
  localparam int unsigned PSW_PARITY   = 7;
  localparam int unsigned PSW_XLATE    = 1;

  localparam logic [15:0] ADDR_STEP    = 16'h0002;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [2:0]  KEY_RESET    = 3'h0;

  // Selected resource
  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_REG   = 3'h1,
    SEL_SAR   = 3'h3,
    SEL_AKR   = 3'h2,
    SEL_SEG   = 3'h6,
    SEL_MAIN  = 3'h7
  } sel_t;

  // Main storage cycle sequencer
  typedef enum logic [1:0] {
    MS_IDLE  = 2'h0,
    MS_WAIT  = 2'h1,
    MS_DONE  = 2'h3
  } ms_state_t;

endpackage

// ### seg_map_store.sv
/*
  Segmentation register array: 8 stacks of 32 entries.
  Assumes one write port and a combinational read, driven by the console logic.
*/
`timescale 1ns/1ps
module seg_map_store
  import console_access_pkg::*;
#(
  parameter int unsigned STACKS  = 8,
  parameter int unsigned ENTRIES = 32
) (
  input  wire logic                         mclk_i,
  input  wire logic                         ce_i,
  input  wire logic                         we_i,
  input  wire logic [STACK_W+ENTRY_W-1:0]   idx_i,
  input  wire logic [WORD_W-1:0]            wdata_i,
  output      logic [WORD_W-1:0]            rdata_o
);

  initial begin
    if (STACKS * ENTRIES != (1 << (STACK_W + ENTRY_W)))
      $error("seg_map_store: size must match the index width");
  end

  // [R3] 256 entries
  logic [WORD_W-1:0] mem [STACKS*ENTRIES];

  always_ff @(posedge mclk_i) begin
    if (ce_i && we_i) begin
      // [R7] Block, valid, read-only
      mem[idx_i] <= wdata_i & {{BLK_W{1'b1}}, 1'b1, 1'b1, 5'h00};
    end
  end

  assign rdata_o = mem[idx_i];

endmodule

// ### console_storage_access.sv
/*
  Console access logic: key entry shift, store into level registers,
  storage address and key, segmentation registers and main storage.
  Assumes one-cycle key pulses from a debounced panel, a storage port
  with a one-cycle request and a later done pulse with error flags,
  and a register file outside that takes a level write strobe.
*/
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Store writes displayed data to selected level register, stop state only.
// [R2] Operator selects level with Level Select then hex key 0 to 3.
// [R3] Translator holds eight stacks of thirty-two entries, 256 total.
// [R4] Entry chosen by address key stack and top five address bits.
// [R5] Seg-map key advances entry; 31 wraps to 0 and bumps stack key.
// [R6] Store in seg mode writes entry then advances like the seg key.
// [R7] Entry holds nine physical block bits, valid flag, read-only flag.
// [R8] Address key store takes one digit, shown in indicator bits 13-15.
// [R9] Main-storage key reads addressed word, displays it, adds two.
// [R10] Store in main-storage mode writes displayed word, then adds two.
// [R11] With translation on, operator loads address key first.
// [R12] Invalid address suppresses program check, sets status bit 1, check on.
// [R13] Parity error suppresses program check, sets status bit 8, check on.
// [R14] Console error bits cause no interrupt unless check still set.
// [R15] Segment register display and store only in stop state.
// [R16] Four keyed hex digits stored become the console address.
// [R17] Hex digits shift into indicators from the right.
// [R18] Store key ignored outside stop state.
// [R19] Console address writes keep the address low bit unchanged.
// [R20] Without translation the address register is the physical address.
module console_storage_access
  import console_access_pkg::*;
#(
  parameter int unsigned LEVELS = 4
) (
  input  wire logic                mclk_i,
  input  wire logic                rstn_i,
  input  wire logic                ce_i,
  input  wire logic                stop_state_i,
  input  wire logic                hex_key_i,
  input  wire logic [3:0]          hex_val_i,
  input  wire logic                level_sel_key_i,
  input  wire logic                reg_key_i,
  input  wire logic                sar_key_i,
  input  wire logic                akr_key_i,
  input  wire logic                seg_key_i,
  input  wire logic                main_key_i,
  input  wire logic                store_key_i,
  input  wire logic                check_reset_i,
  input  wire logic                run_start_i,
  input  wire logic [WORD_W-1:0]   reg_rdata_i,
  input  wire logic                ms_done_i,
  input  wire logic [WORD_W-1:0]   ms_rdata_i,
  input  wire logic                ms_inv_addr_i,
  input  wire logic                ms_parity_i,
  input  wire logic                xlate_en_i,
  output      logic [WORD_W-1:0]   display_o,
  output      logic [LEVEL_W-1:0]  level_o,
  output      logic                reg_we_o,
  output      logic [WORD_W-1:0]   reg_wdata_o,
  output      logic [WORD_W-1:0]   storage_address_register_o,
  output      logic [STACK_W-1:0]  address_key_register_o,
  output      logic                ms_req_o,
  output      logic                ms_write_o,
  output      logic [PHYS_W-1:0]   ms_addr_o,
  output      logic [WORD_W-1:0]   ms_wdata_o,
  output      logic                check_o,
  output      logic                psw_inv_addr_o,
  output      logic                psw_parity_o,
  output      logic                class_irq_o
);

  initial begin
    if (LEVELS != (1 << LEVEL_W))
      $error("console_storage_access: LEVELS must equal four");
  end

  // ****************************************************
  // State
  // ****************************************************
  sel_t              sel_q;
  ms_state_t         ms_q;
  logic              lvl_pend_q;
  logic              ms_wr_q;
  logic              seg_show_q;
  logic [WORD_W-1:0] seg_rdata;
  logic [STACK_W+ENTRY_W-1:0] seg_idx;

  // Address bits [15:11] number the entry, bit 0 is the word-select low bit
  function automatic logic [STACK_W+ENTRY_W-1:0] seg_next(
    input logic [STACK_W-1:0] key,
    input logic [ENTRY_W-1:0] ent);
    return {key, ent} + 8'h01;
  endfunction

  // ****************************************************
  // Decode
  // ****************************************************
  // [R18] Store ignored out of stop
  wire store_ok  = store_key_i && stop_state_i;
  // [R15] Seg access in stop only
  wire seg_ok    = stop_state_i && (seg_key_i || (store_ok && sel_q == SEL_SEG));
  wire ms_start  = stop_state_i && ms_q == MS_IDLE &&
                   (main_key_i || (store_ok && sel_q == SEL_MAIN));
  wire [ENTRY_W-1:0] cur_ent = storage_address_register_o[WORD_W-1 -: ENTRY_W];
  // [R4] Stack from key, entry from top bits
  assign seg_idx = (seg_key_i && sel_q != SEL_SEG) ?
                   {address_key_register_o, cur_ent} :
                   {address_key_register_o, cur_ent};
  wire [STACK_W+ENTRY_W-1:0] adv_idx = seg_next(address_key_register_o, cur_ent);
  // [R20] Direct address when translation off
  wire [PHYS_W-1:0] phys_addr = xlate_en_i ?
                    {address_key_register_o, 1'b0, storage_address_register_o} :
                    {4'h0, storage_address_register_o};
  wire seg_adv   = (seg_key_i && sel_q == SEL_SEG) || (store_ok && sel_q == SEL_SEG);
  wire ms_err    = ms_done_i && (ms_inv_addr_i || ms_parity_i);

  seg_map_store i_seg_map_store (
    .mclk_i  (mclk_i),
    .ce_i    (ce_i),
    .we_i    (store_ok && sel_q == SEL_SEG),
    .idx_i   (seg_idx),
    .wdata_i (display_o),
    .rdata_o (seg_rdata)
  );

  // ****************************************************
  // Selection and display
  // ****************************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q      <= SEL_NONE;
      lvl_pend_q <= 1'b0;
      level_o    <= '0;
      display_o  <= WORD_RESET;
      reg_we_o   <= 1'b0;
      reg_wdata_o <= WORD_RESET;
      seg_show_q <= 1'b0;
    end else if (ce_i) begin
      reg_we_o <= 1'b0;
      // Refresh the indicators one cycle after the index has moved
      seg_show_q <= seg_adv && stop_state_i;
      if (level_sel_key_i && stop_state_i) begin
        lvl_pend_q <= 1'b1;
      end else if (hex_key_i && lvl_pend_q) begin
        // [R2] Level picked by hex key
        if (hex_val_i < 4'h4)
          level_o <= hex_val_i[LEVEL_W-1:0];
        lvl_pend_q <= 1'b0;
      end else if (hex_key_i) begin
        // [R17] Shift digit in from right
        display_o <= {display_o[WORD_W-5:0], hex_val_i};
      end else if (reg_key_i) begin
        sel_q     <= SEL_REG;
        display_o <= reg_rdata_i;
      end else if (sar_key_i && stop_state_i) begin
        sel_q     <= SEL_SAR;
        display_o <= storage_address_register_o;
      end else if (akr_key_i && sel_q == SEL_SAR) begin
        sel_q     <= SEL_AKR;
        display_o <= {13'h0000, address_key_register_o};
      end else if (seg_ok && sel_q != SEL_SEG) begin
        sel_q     <= SEL_SEG;
        display_o <= seg_rdata;
      end else if (main_key_i && stop_state_i) begin
        sel_q <= SEL_MAIN;
      end else if (store_ok && sel_q == SEL_REG) begin
        // [R1] Level register store
        reg_we_o    <= 1'b1;
        reg_wdata_o <= display_o;
      end else if (store_ok && sel_q == SEL_AKR) begin
        // [R8] Digit shown in bits 13-15
        display_o <= {13'h0000, display_o[STACK_W-1:0]};
      end
      // [R5] Show advanced entry
      if (seg_show_q)
        display_o <= seg_rdata;
      if (ms_done_i && !ms_wr_q && ms_q == MS_WAIT)
        display_o <= ms_rdata_i;
    end
  end

  // ****************************************************
  // Address register and key
  // ****************************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      storage_address_register_o <= WORD_RESET;
      address_key_register_o     <= KEY_RESET;
    end else if (ce_i) begin
      if (store_ok && sel_q == SEL_SAR) begin
        // [R16] Keyed value becomes address
        // [R19] Low bit kept
        storage_address_register_o <= {display_o[WORD_W-1:1],
                                       storage_address_register_o[0]};
      end else if (store_ok && sel_q == SEL_AKR) begin
        // [R8] Save address key
        address_key_register_o <= display_o[STACK_W-1:0];
      end else if (seg_adv && stop_state_i) begin
        // [R5] Entry advance with stack wrap
        // [R6] Store then advance
        address_key_register_o <= adv_idx[STACK_W+ENTRY_W-1 -: STACK_W];
        storage_address_register_o[WORD_W-1 -: ENTRY_W] <= adv_idx[ENTRY_W-1:0];
      end else if (ms_done_i && ms_q == MS_WAIT) begin
        // [R9] Read then add two
        // [R10] Write then add two
        storage_address_register_o <= storage_address_register_o + ADDR_STEP;
      end
    end
  end

  // ****************************************************
  // Main storage cycle and errors
  // ****************************************************
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ms_q           <= MS_IDLE;
      ms_wr_q        <= 1'b0;
      ms_req_o       <= 1'b0;
      ms_write_o     <= 1'b0;
      ms_addr_o      <= '0;
      ms_wdata_o     <= WORD_RESET;
      check_o        <= 1'b0;
      psw_inv_addr_o <= 1'b0;
      psw_parity_o   <= 1'b0;
      class_irq_o    <= 1'b0;
    end else if (ce_i) begin
      ms_req_o    <= 1'b0;
      class_irq_o <= 1'b0;
      case (ms_q)
        MS_IDLE: begin
          if (ms_start) begin
            ms_q       <= MS_WAIT;
            ms_req_o   <= 1'b1;
            ms_wr_q    <= store_ok;
            ms_write_o <= store_ok;
            ms_addr_o  <= phys_addr;
            ms_wdata_o <= display_o;
          end
        end
        MS_WAIT: begin
          if (ms_done_i)
            ms_q <= MS_DONE;
        end
        MS_DONE: ms_q <= MS_IDLE;
        default: ms_q <= MS_IDLE;
      endcase
      // [R12] Invalid address flagged
      if (ms_done_i && ms_inv_addr_i)
        psw_inv_addr_o <= 1'b1;
      // [R13] Parity error flagged
      if (ms_done_i && ms_parity_i)
        psw_parity_o <= 1'b1;
      if (ms_err)
        check_o <= 1'b1;
      else if (check_reset_i)
        check_o <= 1'b0;
      // [R14] Interrupt only if check still on
      if (run_start_i && check_o && (psw_inv_addr_o || psw_parity_o))
        class_irq_o <= 1'b1;
    end
  end

endmodule

// ### console_mem_model.sv
/* Main storage model for the console storage port.
   Assumes one-cycle requests held steady until the done pulse. */
`timescale 1ns/1ps
module console_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  dly_i,
  input  wire logic        inv_i,
  input  wire logic        par_i,
  output      logic        done_o,
  output      logic [15:0] rdata_o,
  output      logic        inv_o,
  output      logic        par_o
);
  logic [15:0] mem [0:63];
  logic [19:0] a_q;
  logic [3:0]  cnt_q;
  logic        busy_q = 1'b0;
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {done_o, rdata_o, inv_o, par_o} = '0;
  end
  // Read data churns outside the done cycle
  always @(posedge mclk_i) begin
    done_o <= 1'b0;
    inv_o <= 1'b0;
    par_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i) begin
      busy_q <= 1'b1;
      cnt_q <= dly_i;
      a_q <= addr_i;
      if (write_i) mem[addr_i[6:1]] <= wdata_i;
    end else if (busy_q && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    else if (busy_q) begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
      rdata_o <= mem[a_q[6:1]];
      inv_o <= inv_i;
      par_o <= par_i;
    end
  end
endmodule

// ### console_storage_access_chk.sv
/* Port assertions for the console access block.
   Assumes it is bound into console_storage_access. */
`timescale 1ns/1ps
module console_storage_access_chk
  import console_access_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                rstn_i,
  input wire logic                ce_i,
  input wire logic                stop_state_i,
  input wire logic                hex_key_i,
  input wire logic [3:0]          hex_val_i,
  input wire logic                level_sel_key_i,
  input wire logic                store_key_i,
  input wire logic                run_start_i,
  input wire logic                ms_done_i,
  input wire logic [WORD_W-1:0]   ms_rdata_i,
  input wire logic                ms_inv_addr_i,
  input wire logic                ms_parity_i,
  input wire logic                xlate_en_i,
  input wire logic [WORD_W-1:0]   display_o,
  input wire logic                reg_we_o,
  input wire logic [WORD_W-1:0]   storage_address_register_o,
  input wire logic [STACK_W-1:0]  address_key_register_o,
  input wire logic                ms_req_o,
  input wire logic                ms_write_o,
  input wire logic [PHYS_W-1:0]   ms_addr_o,
  input wire logic [WORD_W-1:0]   ms_wdata_o,
  input wire logic                check_o,
  input wire logic                psw_inv_addr_o,
  input wire logic                psw_parity_o,
  input wire logic                class_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic lvl_q;
  // Level select pending until the next hex key
  always_ff @(posedge mclk_i or negedge rstn_i)
    if (!rstn_i) lvl_q <= 1'b0;
    else if (ce_i && (level_sel_key_i || hex_key_i)) lvl_q <= level_sel_key_i;
  store_ignored_a:
    assert property (store_key_i && !stop_state_i |=> !reg_we_o && !ms_req_o
      && $stable(storage_address_register_o)) else $error("store acted outside stop");
  hex_shift_a:
    assert property (hex_key_i && ce_i && stop_state_i && !level_sel_key_i && !lvl_q
      |=> display_o === {$past(display_o[11:0]), $past(hex_val_i)}) else $error("hex shift");
  sar_even_a:
    assert property (storage_address_register_o[0] == $past(storage_address_register_o[0]))
      else $error("address low bit moved");
  phys_addr_a:
    assert property (ms_req_o |-> ms_addr_o == (xlate_en_i ? {address_key_register_o, 1'b0,
      storage_address_register_o} : {4'h0, storage_address_register_o}))
      else $error("storage address");
  sar_step_a:
    assert property (ms_done_i && ce_i && !ms_inv_addr_i && !ms_parity_i
      |=> storage_address_register_o == $past(storage_address_register_o) + 16'h0002)
      else $error("address step");
  read_show_a:
    assert property (ms_done_i && ce_i && !ms_write_o && !ms_inv_addr_i && !ms_parity_i
      |=> display_o == $past(ms_rdata_i)) else $error("read not shown");
  inv_flag_a:
    assert property (ms_done_i && ce_i && ms_inv_addr_i |=> psw_inv_addr_o && check_o)
      else $error("invalid address flag");
  par_flag_a:
    assert property (ms_done_i && ce_i && ms_parity_i |=> psw_parity_o && check_o)
      else $error("parity flag");
  no_irq_a:
    assert property (run_start_i && !check_o |=> !class_irq_o [*2]) else $error("irq");
  write_data_a:
    assert property (ms_req_o && ms_write_o |-> ms_wdata_o == display_o)
      else $error("write data");
endmodule
bind console_storage_access console_storage_access_chk i_console_storage_access_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .stop_state_i(stop_state_i),
  .hex_key_i(hex_key_i), .hex_val_i(hex_val_i), .level_sel_key_i(level_sel_key_i),
  .store_key_i(store_key_i), .run_start_i(run_start_i), .ms_done_i(ms_done_i),
  .ms_rdata_i(ms_rdata_i), .ms_inv_addr_i(ms_inv_addr_i), .ms_parity_i(ms_parity_i),
  .xlate_en_i(xlate_en_i), .display_o(display_o), .reg_we_o(reg_we_o),
  .storage_address_register_o(storage_address_register_o),
  .address_key_register_o(address_key_register_o), .ms_req_o(ms_req_o),
  .ms_write_o(ms_write_o), .ms_addr_o(ms_addr_o), .ms_wdata_o(ms_wdata_o),
  .check_o(check_o), .psw_inv_addr_o(psw_inv_addr_o), .psw_parity_o(psw_parity_o),
  .class_irq_o(class_irq_o));

// ### console_storage_access_tb.sv
/* Self-checking bench for the console access block.
   Assumes the storage model and checker are compiled before it. */
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t ns: %s", $time, m); end end
module console_storage_access_tb
  import console_access_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        stop_q = 1'b1;
  logic        ce_q = 1'b1;
  logic        xlate_q = 1'b0;
  logic        crst_q = 1'b0;
  logic        run_q = 1'b0;
  logic        inv_q = 1'b0;
  logic        par_q = 1'b0;
  logic [3:0]  dly_q = 4'h3;
  logic [7:0]  key_q = 8'h00;
  logic [3:0]  hex_q = 4'h0;
  logic        done, inv, par, we, req, wr, chk, pinv, ppar, irq;
  logic [15:0] rdat, disp, storage_address_register, rwd, mwd, wcap;
  logic [19:0] addr, acap;
  logic [2:0]  address_key_register;
  logic [1:0]  lvl;
  int          err_count = 0;
  int          num_checks = 0;
  initial forever #25 mclk_i = ~mclk_i;
  console_storage_access i_console_storage_access (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_q), .stop_state_i(stop_q),
    .hex_key_i(key_q[1]), .hex_val_i(hex_q), .level_sel_key_i(key_q[0]),
    .reg_key_i(key_q[2]), .sar_key_i(key_q[3]), .akr_key_i(key_q[4]), .seg_key_i(key_q[5]),
    .main_key_i(key_q[6]), .store_key_i(key_q[7]), .check_reset_i(crst_q),
    .run_start_i(run_q), .reg_rdata_i(16'h0000), .ms_done_i(done), .ms_rdata_i(rdat),
    .ms_inv_addr_i(inv), .ms_parity_i(par), .xlate_en_i(xlate_q), .display_o(disp),
    .level_o(lvl), .reg_we_o(we), .reg_wdata_o(rwd), .storage_address_register_o(storage_address_register),
    .address_key_register_o(address_key_register), .ms_req_o(req), .ms_write_o(wr), .ms_addr_o(addr),
    .ms_wdata_o(mwd), .check_o(chk), .psw_inv_addr_o(pinv), .psw_parity_o(ppar),
    .class_irq_o(irq));
  console_mem_model i_console_mem_model (.mclk_i(mclk_i), .req_i(req), .write_i(wr),
    .addr_i(addr), .wdata_i(mwd), .dly_i(dly_q), .inv_i(inv_q), .par_i(par_q),
    .done_o(done), .rdata_o(rdat), .inv_o(inv), .par_o(par));
  always @(posedge mclk_i) begin
    if (we) wcap <= rwd;
    if (req) acap <= addr;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Key index: 0 level, 1 hex, 2 reg, 3 sar, 4 akr, 5 seg, 6 main, 7 store
  task automatic press(input int k, input logic [3:0] v);
    @(posedge mclk_i);
    key_q <= 8'h01 << k;
    hex_q <= v;
    @(posedge mclk_i);
    key_q <= 8'h00;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic hex4(input logic [15:0] v);
    for (int i = 3; i >= 0; i--) press(1, v[i*4 +: 4]);
  endtask
  task automatic ms_wait();
    int n;
    for (n = 0; n < 50 && done !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    if (n == 50) begin
      err_count++;
      $display("unexpected at %0t ns: storage hang", $time);
      conclude();
    end else begin
      repeat (2) @(posedge mclk_i);
      #1;
    end
  endtask
  task automatic set_sar(input logic [15:0] v);
    press(3, 4'h0); hex4(v); press(7, 4'h0);
  endtask
  task automatic set_akr(input logic [3:0] k);
    press(3, 4'h0); press(4, 4'h0); press(1, k); press(7, 4'h0);
  endtask
  task automatic t_sar();
    press(3, 4'h0);
    hex4(16'h1235);
    `CHK(disp, 16'h1235, "keyed display")
    press(7, 4'h0);
    `CHK(storage_address_register, 16'h1234, "address load")
    @(posedge mclk_i);
    stop_q <= 1'b0;
    // New digit so an accepted store would move the address
    press(1, 4'h8);
    press(7, 4'h0);
    `CHK(storage_address_register, 16'h1234, "store while running")
    @(posedge mclk_i);
    stop_q <= 1'b1;
    ce_q <= 1'b0;
    press(1, 4'h9);
    `CHK(disp, 16'h2358, "frozen by enable")
    @(posedge mclk_i);
    ce_q <= 1'b1;
    $display("test sar done");
  endtask
  task automatic t_akr();
    press(3, 4'h0); press(4, 4'h0); press(1, 4'h5);
    `CHK(disp[2:0], 3'h5, "key digit shown")
    press(7, 4'h0);
    `CHK(address_key_register, 3'h5, "address key")
    $display("test akr done");
  endtask
  task automatic t_level();
    press(0, 4'h0); press(1, 4'h2);
    `CHK(lvl, 2'h2, "level select")
    press(0, 4'h0); press(1, 4'h5);
    `CHK(lvl, 2'h2, "level above three")
    press(2, 4'h0); hex4(16'habcd); press(7, 4'h0);
    `CHK(wcap, 16'habcd, "register store")
    $display("test level done");
  endtask
  task automatic t_main();
    set_sar(16'h0040); press(6, 4'h0); ms_wait();
    `CHK(storage_address_register, 16'h0042, "read step")
    hex4(16'h1111); press(7, 4'h0); ms_wait();
    hex4(16'h2222); press(7, 4'h0); ms_wait();
    `CHK(storage_address_register, 16'h0046, "write step")
    set_sar(16'h0042); press(6, 4'h0); ms_wait();
    `CHK(disp, 16'h1111, "read back")
    `CHK(acap, 20'h00042, "direct address")
    @(posedge mclk_i); xlate_q <= 1'b1; dly_q <= 4'h9;
    press(6, 4'h0); ms_wait();
    `CHK(disp, 16'h2222, "second word")
    `CHK(acap, {3'h5, 1'b0, 16'h0044}, "mapped address")
    @(posedge mclk_i); xlate_q <= 1'b0;
    $display("test main done");
  endtask
  task automatic t_err();
    @(posedge mclk_i);
    inv_q <= 1'b1;
    press(6, 4'h0);
    ms_wait();
    `CHK({pinv, chk}, 2'b11, "invalid address")
    @(posedge mclk_i);
    inv_q <= 1'b0;
    par_q <= 1'b1;
    press(6, 4'h0);
    ms_wait();
    `CHK({ppar, chk}, 2'b11, "parity error")
    // Return to run with the check indicator still on
    @(posedge mclk_i);
    par_q <= 1'b0;
    run_q <= 1'b1;
    @(posedge mclk_i);
    run_q <= 1'b0;
    #1;
    `CHK(irq, 1'b1, "class irq with check")
    @(posedge mclk_i);
    crst_q <= 1'b1;
    @(posedge mclk_i);
    crst_q <= 1'b0;
    run_q <= 1'b1;
    @(posedge mclk_i);
    run_q <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      #1;
      `CHK(irq, 1'b0, "class irq")
      @(posedge mclk_i);
    end
    `CHK({pinv, ppar, chk}, 3'b110, "flags kept")
    $display("test errors done");
  endtask
  task automatic t_seg();
    set_sar(16'hf800); set_akr(4'h7); press(5, 4'h0);
    hex4(16'hffe7); press(7, 4'h0);
    `CHK({address_key_register, storage_address_register[15:11]}, 8'h00, "store wrap")
    hex4(16'h123f); press(7, 4'h0);
    set_sar(16'hf800); set_akr(4'h7); press(5, 4'h0);
    `CHK(disp, 16'hffe0, "last entry")
    press(5, 4'h0);
    `CHK({disp, address_key_register}, {16'h1220, 3'h0}, "key wrap")
    @(posedge mclk_i); stop_q <= 1'b0;
    press(5, 4'h0);
    `CHK(disp, 16'h1220, "seg while running")
    $display("test seg done");
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_sar(); t_akr(); t_level(); t_main(); t_err(); t_seg();
    conclude();
  end
endmodule
